// [design/link_deser_cfg.svh]
`ifndef LINK_DESER_CFG_SVH
`define LINK_DESER_CFG_SVH

// ****************************************************************
// Register map.
// ****************************************************************
`define CTRL_INDEX           8'h04
`define EQ_INDEX             8'h05
`define CTRL_ADDR            (`CTRL_INDEX << 2)
`define EQ_ADDR              (`EQ_INDEX << 2)

// ****************************************************************
// Field positions of the link control and status register.
// ****************************************************************
`define LOCK_BIT             7
`define OUTDIS_BIT           6
`define PRBS_BIT             5
`define SLEEP_BIT            4
`define TYPE_HI              3
`define TYPE_LO              2
`define REV_BIT              1
`define FWD_BIT              0

// ****************************************************************
// Field positions of the equalizer and conversion register.
// ****************************************************************
`define ADDR_SEND_BIT        7
`define HPF_HI               6
`define HPF_LO               5
`define HF_OFF_BIT           4
`define GAIN_HI              3
`define GAIN_LO              0

// ****************************************************************
// Encodings and reset values.
// ****************************************************************
`define TYPE_I2C             2'h0
`define TYPE_UART            2'h1
`define GAIN_BAD_TOP         2'h3
`define RST_OUTDIS           1'h0
`define RST_PRBS             1'h0
`define RST_TYPE             2'h0
`define RST_REV              1'h1
`define RST_FWD              1'h1
`define RST_ADDR_SEND        1'h0
`define RST_HPF              2'h1
`define RST_HF_OFF           1'h0
`define GAIN_EQS_HIGH        4'h4
`define GAIN_EQS_LOW         4'h9
`define RST_GAIN             `GAIN_EQS_LOW
`define RST_SLEEP            1'h0
`define BYTE_W               8
`define SYNC_WAIT            2'h2

`endif

// [design/link_deser_control_regs.sv]
`include "link_deser_cfg.svh"

// Operation
// - Control bit 7 mirrors lock pin, read-only.
// - Control bit 4 sleep; strap-loaded power-up value.
// - Type field 00 I2C, 01 UART; reset 00.
// - Type 10 or 11 disables peripheral interface.
// - Control bit 1 enables reverse channel; reset 1.
// - Control bit 0 enables forward channel; reset 1.
// - Bit 7 chooses address byte or command-only.
// - Highpass field selects cutoff; resets to 01.
// - Gain codes 0000-1011; 11XX refused; bit4 boost-off.
// - Gain loads 0100 if eq pin high, else 1001.
module link_deser_control_regs #(
   parameter int ADDR_W = 8
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   input  wire logic              lock_pin,
   input  wire logic              control_side_pin,
   input  wire logic              mode_select_pin,
   input  wire logic              eq_select_pin,
   output logic                   output_disable_bit,
   output logic                   prbs_test_enable,
   output logic                   sleep_mode,
   output logic [1:0]             peripheral_if_type,
   output logic                   i2c_periph_enable,
   output logic                   uart_periph_enable,
   output logic                   reverse_channel_enable,
   output logic                   forward_channel_enable,
   output logic                   addr_send_select,
   output logic [1:0]             eq_highpass_select,
   output logic                   hf_boost_disable,
   output logic [3:0]             eq_boost_gain
);

   // ****************************************************************
   // Pin synchronisation.
   // ****************************************************************
   logic [3:0] pins_s;
   logic       lock_s;
   logic       cds_s;
   logic       ms_s;
   logic       eqs_s;

   pin_sync #(
      .WIDTH   (4)
   ) u_pin_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  ({lock_pin, control_side_pin, mode_select_pin,
                 eq_select_pin}),
      .pin_out (pins_s)
   );

   assign lock_s = pins_s[3];
   assign cds_s  = pins_s[2];
   assign ms_s   = pins_s[1];
   assign eqs_s  = pins_s[0];

   // ****************************************************************
   // State and bus decode.
   // ****************************************************************
   link_deser_pkg::state_type       state_r;
   link_deser_pkg::state_type       state_nxt;
   link_deser_pkg::sync_count_type  wait_r;
   link_deser_pkg::sync_count_type  wait_nxt;

   logic              hit_ctrl;
   logic              hit_eq;
   logic              setup_ph;
   logic              access_ph;
   logic              wr_done;
   logic              wr_lane;
   logic [`BYTE_W-1:0] wbyte;
   logic [`BYTE_W-1:0] ctrl_view;
   logic [`BYTE_W-1:0] eq_view;

   assign hit_ctrl  = (paddr == ADDR_W'(`CTRL_ADDR));
   assign hit_eq    = (paddr == ADDR_W'(`EQ_ADDR));
   assign setup_ph  = psel && !penable;
   assign access_ph = psel && penable;
   assign wr_done   = access_ph && pwrite && state_r.pready;
   assign wr_lane   = pstrb[0];
   assign wbyte     = pwdata[`BYTE_W-1:0];

   // ****************************************************************
   // Read views of both registers.
   // ****************************************************************
   always_comb begin
      ctrl_view = '0;
      ctrl_view[`LOCK_BIT]   = lock_s;
      ctrl_view[`OUTDIS_BIT] = state_r.output_disable;
      ctrl_view[`PRBS_BIT]   = state_r.prbs_test_enable;
      ctrl_view[`SLEEP_BIT]  = state_r.sleep;
      ctrl_view[`TYPE_HI:`TYPE_LO] = state_r.peripheral_if_type;
      ctrl_view[`REV_BIT]    = state_r.reverse_channel_enable;
      ctrl_view[`FWD_BIT]    = state_r.forward_channel_enable;
      eq_view = '0;
      eq_view[`ADDR_SEND_BIT]   = state_r.addr_send_select;
      eq_view[`HPF_HI:`HPF_LO]  = state_r.eq_highpass_select;
      eq_view[`HF_OFF_BIT]      = state_r.hf_boost_disable;
      eq_view[`GAIN_HI:`GAIN_LO] = state_r.eq_boost_gain;
   end

   // ****************************************************************
   // Next-state logic.
   // ****************************************************************
   always_comb begin
      state_nxt = state_r;
      wait_nxt  = wait_r;

      unique case (state_r.boot)
         link_deser_pkg::boot_sync: begin
            wait_nxt.stage0 = wait_r.stage0 + 2'h1;
            if (wait_r.stage0 == `SYNC_WAIT) begin
               state_nxt.boot = link_deser_pkg::boot_load;
            end
         end
         link_deser_pkg::boot_load: begin
            state_nxt.sleep = cds_s && ms_s;
            if (eqs_s) begin
               state_nxt.eq_boost_gain = `GAIN_EQS_HIGH;
            end else begin
               state_nxt.eq_boost_gain = `GAIN_EQS_LOW;
            end
            state_nxt.boot = link_deser_pkg::boot_run;
         end
         link_deser_pkg::boot_run: begin
            wait_nxt.stage1 = wait_r.stage1;
         end
         default: begin
            state_nxt.boot = link_deser_pkg::boot_sync;
         end
      endcase

      // Answer in the first cycle of the access phase once straps are loaded.
      if (state_r.pready) begin
         state_nxt.pready  = 1'h0;
         state_nxt.pslverr = 1'h0;
      end else if ((setup_ph || access_ph) &&
                   state_r.boot == link_deser_pkg::boot_run) begin
         state_nxt.pready  = 1'h1;
         state_nxt.pslverr = !(hit_ctrl || hit_eq);
         state_nxt.prdata  = '0;
         if (!pwrite && hit_ctrl) begin
            state_nxt.prdata[`BYTE_W-1:0] = ctrl_view;
         end else if (!pwrite && hit_eq) begin
            state_nxt.prdata[`BYTE_W-1:0] = eq_view;
         end
      end

      if (wr_done && wr_lane && hit_ctrl) begin
         state_nxt.output_disable   = wbyte[`OUTDIS_BIT];
         state_nxt.prbs_test_enable = wbyte[`PRBS_BIT];
         state_nxt.sleep            = wbyte[`SLEEP_BIT];
         state_nxt.peripheral_if_type =
            wbyte[`TYPE_HI:`TYPE_LO];
         state_nxt.reverse_channel_enable = wbyte[`REV_BIT];
         state_nxt.forward_channel_enable = wbyte[`FWD_BIT];
      end

      if (wr_done && wr_lane && hit_eq) begin
         state_nxt.addr_send_select   = wbyte[`ADDR_SEND_BIT];
         state_nxt.eq_highpass_select = wbyte[`HPF_HI:`HPF_LO];
         state_nxt.hf_boost_disable   = wbyte[`HF_OFF_BIT];
         if (wbyte[`GAIN_HI:`GAIN_HI-1] != `GAIN_BAD_TOP) begin
            state_nxt.eq_boost_gain = wbyte[`GAIN_HI:`GAIN_LO];
         end
      end

      // Peripheral interface selects follow the type field.
      state_nxt.i2c_enable  =
         (state_nxt.peripheral_if_type == `TYPE_I2C);
      state_nxt.uart_enable =
         (state_nxt.peripheral_if_type == `TYPE_UART);
   end

   // ****************************************************************
   // State register.
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r.boot                   <= link_deser_pkg::boot_sync;
         state_r.pready                 <= 1'h0;
         state_r.pslverr                <= 1'h0;
         state_r.prdata                 <= '0;
         state_r.output_disable         <= `RST_OUTDIS;
         state_r.prbs_test_enable       <= `RST_PRBS;
         state_r.sleep                  <= `RST_SLEEP;
         state_r.peripheral_if_type     <= `RST_TYPE;
         state_r.reverse_channel_enable <= `RST_REV;
         state_r.forward_channel_enable <= `RST_FWD;
         state_r.addr_send_select       <= `RST_ADDR_SEND;
         state_r.eq_highpass_select     <= `RST_HPF;
         state_r.hf_boost_disable       <= `RST_HF_OFF;
         state_r.eq_boost_gain          <= `RST_GAIN;
         state_r.i2c_enable             <= (`RST_TYPE == `TYPE_I2C);
         state_r.uart_enable            <= (`RST_TYPE == `TYPE_UART);
         wait_r                         <= '0;
      end else begin
         state_r <= state_nxt;
         wait_r  <= wait_nxt;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   assign pready                 = state_r.pready;
   assign prdata                 = state_r.prdata;
   assign pslverr                = state_r.pslverr;
   assign output_disable_bit     = state_r.output_disable;
   assign prbs_test_enable       = state_r.prbs_test_enable;
   assign sleep_mode             = state_r.sleep;
   assign peripheral_if_type     = state_r.peripheral_if_type;
   assign i2c_periph_enable      = state_r.i2c_enable;
   assign uart_periph_enable     = state_r.uart_enable;
   assign reverse_channel_enable = state_r.reverse_channel_enable;
   assign forward_channel_enable = state_r.forward_channel_enable;
   assign addr_send_select       = state_r.addr_send_select;
   assign eq_highpass_select     = state_r.eq_highpass_select;
   assign hf_boost_disable       = state_r.hf_boost_disable;
   assign eq_boost_gain          = state_r.eq_boost_gain;

endmodule

// [design/link_deser_pkg.sv]
package link_deser_pkg;

   // ****************************************************************
   // Start-up sequence: wait for the pin synchroniser, load straps, run.
   // ****************************************************************
   typedef enum logic [1:0] {
      boot_sync,
      boot_load,
      boot_run
   } boot_type;

   typedef struct packed {
      boot_type    boot;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        output_disable;
      logic        prbs_test_enable;
      logic        sleep;
      logic [1:0]  peripheral_if_type;
      logic        reverse_channel_enable;
      logic        forward_channel_enable;
      logic        addr_send_select;
      logic [1:0]  eq_highpass_select;
      logic        hf_boost_disable;
      logic [3:0]  eq_boost_gain;
      logic        i2c_enable;
      logic        uart_enable;
   } state_type;

   typedef struct packed {
      logic [1:0] stage0;
      logic [1:0] stage1;
   } sync_count_type;

endpackage

// [design/pin_sync.sv]
module pin_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_out
);

   // ****************************************************************
   // Two flip-flops per pin; only the second stage is read outside.
   // ****************************************************************
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r  <= '0;
         pin_out <= '0;
      end else begin
         meta_r  <= pin_in;
         pin_out <= meta_r;
      end
   end

endmodule

// [tb/link_deser_control_regs_monitor.sv]
// ****
// Checker on the ports of the control register block.
// ****
module link_deser_control_regs_monitor #(
   parameter int ADDR_W = 8
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic              pready,
   input wire logic              i2c_periph_enable,
   input wire logic              uart_periph_enable,
   input wire logic [1:0]        peripheral_if_type,
   input wire logic              reverse_channel_enable,
   input wire logic              forward_channel_enable,
   input wire logic              output_disable_bit,
   input wire logic [1:0]        eq_highpass_select,
   input wire logic [3:0]        eq_boost_gain
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_done;
   logic ctrl_wr;
   logic eq_wr;
   assign wr_done = psel && penable && pready && pwrite && pstrb[0];
   assign ctrl_wr = wr_done && paddr == ADDR_W'(8'h10);
   assign eq_wr = wr_done && paddr == ADDR_W'(8'h14);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_i2c_decode: assert property (
      i2c_periph_enable == (peripheral_if_type == 2'h0))
      else $error("I2C enable does not follow the type field");
   chk_uart_decode: assert property (
      uart_periph_enable == (peripheral_if_type == 2'h1))
      else $error("UART enable does not follow the type field");
   chk_type_off: assert property (
      peripheral_if_type[1] |-> !i2c_periph_enable && !uart_periph_enable)
      else $error("Peripheral interface not disabled");
   chk_fwd_write: assert property (
      ctrl_wr |=> forward_channel_enable == $past(pwdata[0]))
      else $error("Forward channel enable not written");
   chk_rev_write: assert property (
      ctrl_wr |=> reverse_channel_enable == $past(pwdata[1]))
      else $error("Reverse channel enable not written");
   chk_outdis_write: assert property (
      ctrl_wr |=> output_disable_bit == $past(pwdata[6]))
      else $error("Output disable bit not written");
   chk_hpf_write: assert property (
      eq_wr |=> eq_highpass_select == $past(pwdata[6:5]))
      else $error("Highpass field not written");
   chk_gain_refused: assert property (
      eq_wr && pwdata[3:2] == 2'h3 |=> $stable(eq_boost_gain))
      else $error("Forbidden gain code was accepted");
   chk_gain_legal: assert property (
      eq_boost_gain[3:2] != 2'h3)
      else $error("Gain field holds a forbidden code");
endmodule

bind link_deser_control_regs link_deser_control_regs_monitor #(
   .ADDR_W(ADDR_W)
) mon (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .pready, .i2c_periph_enable, .uart_periph_enable, .peripheral_if_type,
   .reverse_channel_enable, .forward_channel_enable, .output_disable_bit,
   .eq_highpass_select, .eq_boost_gain
);

// [tb/link_deser_control_regs_test.sv]
module link_deser_control_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Stimulus, expected values and comparisons.
   // ****
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h0;
   logic        lock_pin = 1'h0;
   logic        control_side_pin = 1'h0;
   logic        mode_select_pin = 1'h0;
   logic        eq_select_pin = 1'h0;
   logic [31:0] prdata;
   logic [1:0]  peripheral_if_type;
   logic [1:0]  eq_highpass_select;
   logic [3:0]  eq_boost_gain;
   logic        pready, pslverr, output_disable_bit, prbs_test_enable;
   logic        sleep_mode, i2c_periph_enable, uart_periph_enable;
   logic        reverse_channel_enable, forward_channel_enable;
   logic        addr_send_select, hf_boost_disable;
   logic [6:0]  ctrl_m;
   logic [7:0]  eq_m;
   logic [7:0]  d;
   logic [9:0]  exp_q[$];
   int          miscompares = 0;
   int          tests_run = 0;
   int          cycles = 0;
   wire  [6:0]  ctrl_o = {output_disable_bit, prbs_test_enable, sleep_mode,
      peripheral_if_type, reverse_channel_enable, forward_channel_enable};
   wire  [7:0]  eq_o = {addr_send_select, eq_highpass_select,
      hf_boost_disable, eq_boost_gain};

   always #12.5 pclk = ~pclk;

   link_deser_control_regs DUT (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .pready, .prdata, .pslverr, .lock_pin, .control_side_pin,
      .mode_select_pin, .eq_select_pin, .output_disable_bit,
      .prbs_test_enable, .sleep_mode, .peripheral_if_type,
      .i2c_periph_enable, .uart_periph_enable, .reverse_channel_enable,
      .forward_channel_enable, .addr_send_select, .eq_highpass_select,
      .hf_boost_disable, .eq_boost_gain
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("Compares %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   function automatic logic bad(input logic [7:0] a);
      return a != 8'h10 && a != 8'h14;
   endfunction

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [7:0] v, input logic s,
                      input logic [9:0] note);
      exp_q.push_back(note);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'($urandom), v};
      pstrb <= {3'($urandom), s};
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(negedge pclk);
      end while (pready !== 1'h1);
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      apb(1'h1, a, v, 1'h1, {1'h0, bad(a), 8'h00});
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'h0, a, 8'($urandom), 1'h1, {1'h1, bad(a), e});
   endtask

   task automatic idle;
      psel <= 1'h0;
      penable <= 1'h0;
      repeat (3) @(posedge pclk);
   endtask

   task automatic ports;
      idle;
      @(negedge pclk);
      check(32'(ctrl_o), 32'(ctrl_m));
      check(32'(eq_o), 32'(eq_m));
      check({i2c_periph_enable, uart_periph_enable},
            {ctrl_m[3:2] == 2'h0, ctrl_m[3:2] == 2'h1});
      @(posedge pclk);
   endtask

   task automatic rst(input logic cs, input logic ms, input logic eq,
                      input logic lk);
      @(posedge pclk);
      presetn <= 1'b0;
      control_side_pin <= cs;
      mode_select_pin <= ms;
      eq_select_pin <= eq;
      lock_pin <= lk;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      ctrl_m = {2'h0, cs & ms, 4'h3};
      eq_m = {4'h2, eq ? 4'h4 : 4'h9};
      repeat (6) @(posedge pclk);
   endtask

   always @(posedge pclk) begin
      logic [9:0] note;
      if (psel && penable && pready === 1'h1) begin
         note = exp_q.size() > 0 ? exp_q.pop_front() : 10'h3ff;
         check(32'(pslverr), 32'(note[8]));
         if (note[9]) check(prdata, {24'h0, note[7:0]});
      end
   end

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         close_out;
      end
   end

   initial begin
      void'($urandom(32'h82fe));
      rst(1'h1, 1'h1, 1'h1, 1'h1);
      rd(8'h10, {1'h1, ctrl_m});
      rd(8'h14, eq_m);
      ports;
      $display("Test reset values done");
      for (int t = 0; t < 4; t++) begin
         lock_pin <= t[0];
         d = 8'($urandom);
         d[3:2] = t[1:0];
         idle;
         wr(8'h10, d);
         ctrl_m = d[6:0];
         rd(8'h10, {t[0], ctrl_m});
         ports;
      end
      $display("Test control writes done");
      for (int i = 0; i < 16; i++) begin
         d = 8'($urandom);
         d[6:5] = i[1:0];
         if (i == 5) d[3:2] = 2'h3;
         wr(8'h14, d);
         eq_m[7:4] = d[7:4];
         if (d[3:2] != 2'h3) eq_m[3:0] = d[3:0];
         rd(8'h14, eq_m);
      end
      ports;
      $display("Test equalizer writes done");
      wr(8'h18, 8'($urandom));
      rd(8'h18, 8'h00);
      apb(1'h1, 8'h10, ~{1'h0, ctrl_m}, 1'h0, 10'h000);
      rd(8'h10, {lock_pin, ctrl_m});
      ports;
      $display("Test refused writes done");
      rst(1'h1, 1'h0, 1'h0, 1'h0);
      rd(8'h10, {1'h0, ctrl_m});
      rd(8'h14, eq_m);
      ports;
      $display("Test second reset done");
      close_out;
   end
endmodule
